// File: dual_dac_serial_control.sv
// Serial command decoder with double-buffered two-channel code registers
//
// What this block does
// - While strobe is low, rising serial clock edges shift data bits into the shift register.
// - While strobe is high, serial clock is ignored; no bits enter.
// - Each rising serial clock edge while selected samples data into 16-bit register.
// - Word is 4-bit control code, 10-bit conversion code, two ignored pad bits.
// - Strobe rising edge decodes control code and executes selected operations.
// - Each channel has a 10-bit input register and a 10-bit output register.
// - Input registers load singly or together; output registers always update together.
// - After reset both outputs are at zero scale.
// - Code 1110 sleeps: outputs high impedance, all registers retained.
// - Sleep command ignores its conversion code.
// - While asleep, codes 0001 and 0010 load input registers without waking.
// - Code 1000 wakes and copies both input registers to output registers.
// - On waking, non-updated channels resume driving their held value.
// - Code 0000 changes nothing.
// - Codes 1001/1010 load A/B input, update both outputs, wake.
// - Code 1101 only wakes, registers unchanged.
// - Code 1111 loads both inputs with same code, updates outputs, wakes.
`timescale 1ns/1ps
module dual_dac_serial_control
  import dac_ctrl_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 nrst,
  input  wire logic                 select_load_strobe_n,
  input  wire logic                 serial_clk,
  input  wire logic                 serial_data,
  output pair_type                  out_codes,
  output logic                      out_enable,
  output logic                      asleep,
  output logic [CODE_BITS-1:0]      last_control_code,
  output logic                      word_complete,
  output logic                      command_done
);

  // ****************************************************************
  // Input synchronisation and edge detection
  // ****************************************************************
  logic [2:0] pins_s;
  logic       strobe_n_q;
  logic       sclk_q;

  // Strobe passes inverted so the zero reset of the synchroniser reads as idle high
  sync2 #(
    .WIDTH (3)
  ) u_sync (
    .clk      (clk),
    .nrst     (nrst),
    .async_in ({~select_load_strobe_n, serial_clk, serial_data}),
    .sync_out (pins_s)
  );

  logic strobe_n_s;
  logic sclk_s;
  logic data_s;
  assign strobe_n_s = ~pins_s[2];
  assign sclk_s     = pins_s[1];
  assign data_s     = pins_s[0];

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      strobe_n_q <= 1'b1;
      sclk_q     <= 1'b0;
    end else begin
      strobe_n_q <= strobe_n_s;
      sclk_q     <= sclk_s;
    end
  end

  logic sclk_rise;
  logic strobe_rise;
  logic strobe_fall;
  assign sclk_rise   = sclk_s & ~sclk_q & ~strobe_n_s;
  assign strobe_rise = strobe_n_s & ~strobe_n_q;
  assign strobe_fall = ~strobe_n_s & strobe_n_q;

  // ****************************************************************
  // Shift register and bit counter
  // ****************************************************************
  logic [WORD_BITS-1:0] shift_q;
  logic [CNT_BITS-1:0]  count_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      shift_q <= SHIFT_RESET;
    end else if (sclk_rise) begin
      shift_q <= {shift_q[WORD_BITS-2:0], data_s};
    end
  end

  // Counter saturates so extra bits still shift but never wrap the count
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      count_q <= CNT_RESET;
    end else if (strobe_fall) begin
      count_q <= CNT_RESET;
    end else if (sclk_rise && count_q != WORD_COUNT) begin
      count_q <= count_q + 5'h01;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      word_complete <= 1'b0;
    end else begin
      word_complete <= (count_q == WORD_COUNT);
    end
  end

  // ****************************************************************
  // Command decode
  // ****************************************************************
  logic [CODE_BITS-1:0] code_w;
  logic [DATA_BITS-1:0] data_w;
  assign code_w = shift_q[CODE_LSB +: CODE_BITS];
  assign data_w = shift_q[DATA_LSB +: DATA_BITS];

  action_type act;

  always_comb begin
    act = '0;
    case (code_w)
      CMD_LOAD_A:     act.load_a = 1'b1;
      CMD_LOAD_B:     act.load_b = 1'b1;
      CMD_UPDATE:     begin
        act.update = 1'b1;
        act.wake   = 1'b1;
      end
      CMD_LOAD_A_UPD: begin
        act.load_a = 1'b1;
        act.update = 1'b1;
        act.wake   = 1'b1;
      end
      CMD_LOAD_B_UPD: begin
        act.load_b = 1'b1;
        act.update = 1'b1;
        act.wake   = 1'b1;
      end
      CMD_WAKE:       act.wake = 1'b1;
      CMD_SLEEP:      act.sleep = 1'b1;
      CMD_LOAD_BOTH:  begin
        act.load_a = 1'b1;
        act.load_b = 1'b1;
        act.update = 1'b1;
        act.wake   = 1'b1;
      end
      default:        act = '0;
    endcase
  end

  // ****************************************************************
  // Input and output registers
  // ****************************************************************
  pair_type input_q;
  pair_type input_next;

  always_comb begin
    input_next = input_q;
    if (act.load_a) begin
      input_next.chan_a = data_w;
    end
    if (act.load_b) begin
      input_next.chan_b = data_w;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      input_q <= '{chan_a: ZERO_SCALE, chan_b: ZERO_SCALE};
    end else if (strobe_rise) begin
      input_q <= input_next;
    end
  end

  // Both channels always transfer together from the freshly loaded inputs
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_codes <= '{chan_a: ZERO_SCALE, chan_b: ZERO_SCALE};
    end else if (strobe_rise && act.update) begin
      out_codes <= input_next;
    end
  end

  // ****************************************************************
  // Sleep and wake state
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      asleep <= 1'b0;
    end else if (strobe_rise && act.sleep) begin
      asleep <= 1'b1;
    end else if (strobe_rise && act.wake) begin
      asleep <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_enable <= 1'b1;
    end else if (strobe_rise && act.sleep) begin
      out_enable <= 1'b0;
    end else if (strobe_rise && act.wake) begin
      out_enable <= 1'b1;
    end
  end

  // ****************************************************************
  // Status
  // ****************************************************************
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_control_code <= 4'h0;
      command_done      <= 1'b0;
    end else begin
      command_done <= strobe_rise;
      if (strobe_rise) begin
        last_control_code <= code_w;
      end
    end
  end

endmodule

// File: dac_ctrl_pkg.sv
// Package: constants, types and command codes of the dual converter control block
package dac_ctrl_pkg;

  localparam int WORD_BITS = 16;
  localparam int CODE_BITS = 4;
  localparam int DATA_BITS = 10;
  localparam int DATA_LSB  = 2;
  localparam int CODE_LSB  = 12;
  localparam int CNT_BITS  = 5;
  localparam logic [CNT_BITS-1:0] WORD_COUNT = 5'h10;

  localparam logic [DATA_BITS-1:0] ZERO_SCALE = 10'h000;
  localparam logic [WORD_BITS-1:0] SHIFT_RESET = 16'h0000;
  localparam logic [CNT_BITS-1:0]  CNT_RESET = 5'h00;

  typedef enum logic [CODE_BITS-1:0] {
    CMD_NOP        = 4'h0,
    CMD_LOAD_A     = 4'h1,
    CMD_LOAD_B     = 4'h2,
    CMD_UPDATE     = 4'h8,
    CMD_LOAD_A_UPD = 4'h9,
    CMD_LOAD_B_UPD = 4'hA,
    CMD_WAKE       = 4'hD,
    CMD_SLEEP      = 4'hE,
    CMD_LOAD_BOTH  = 4'hF
  } cmd_type;

  typedef struct packed {
    logic [DATA_BITS-1:0] chan_a;
    logic [DATA_BITS-1:0] chan_b;
  } pair_type;

  typedef struct packed {
    logic load_a;
    logic load_b;
    logic update;
    logic wake;
    logic sleep;
  } action_type;

endpackage

// File: sync2.sv
// Two-stage synchroniser for asynchronous level inputs
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      meta_q   <= '0;
      sync_out <= '0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end

endmodule

// File: serial_host_model.sv
// Behavioural host driving the three-wire serial link
`timescale 1ns/1ps
module serial_host_model (
  input  wire logic clk,
  output logic      strobe_n,
  output logic      sclk,
  output logic      sdata
);
  initial begin
    strobe_n = 1'b1;
    sclk     = 1'b0;
    sdata    = 1'b0;
  end
  // Half of the 80 ns link period
  task automatic half();
    repeat (8) @(negedge clk);
  endtask
  task automatic send(input logic [15:0] w);
    strobe_n = 1'b0;
    half();
    for (int i = 15; i >= 0; i--) begin
      sdata = w[i];
      half();
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    half();
    strobe_n = 1'b1;
    sdata    = ~sdata;
    half();
  endtask
endmodule

// File: dac_ctrl_sva.sv
// Checker of the converter control outputs
`timescale 1ns/1ps
module dac_ctrl_sva
  import dac_ctrl_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 nrst,
  input wire pair_type             out_codes,
  input wire logic                 out_enable,
  input wire logic                 asleep,
  input wire logic [CODE_BITS-1:0] last_control_code,
  input wire logic                 command_done
);
  default clocking @(posedge clk);
  endclocking
  default disable iff (!nrst);
  wire logic [CODE_BITS-1:0] c = last_control_code;
  wire logic d = command_done;
  reset_zero_a: assert property (!$past(nrst) |-> out_codes == 20'h00000)
    else $error("outputs not zero after reset");
  done_pulse_a: assert property (d |=> !d)
    else $error("done longer than one cycle");
  change_done_a: assert property ($changed(out_codes) || $changed(asleep) |-> d)
    else $error("outputs changed outside a command");
  sleep_mode_a: assert property (d && c == 4'hE |-> asleep && !out_enable)
    else $error("sleep not entered");
  hiz_level_a: assert property (out_enable == !asleep)
    else $error("enable disagrees with sleep");
  wake_mode_a: assert property (d && c inside {4'h8, 4'h9, 4'hA, 4'hD, 4'hF} |-> !asleep)
    else $error("wake not done");
  hold_out_a: assert property (
    d && !(c inside {4'h8, 4'h9, 4'hA, 4'hF}) |-> out_codes == $past(out_codes))
    else $error("outputs changed without update");
  hold_power_a: assert property (
    d && c inside {[4'h0:4'h7], 4'hB, 4'hC} |-> asleep == $past(asleep))
    else $error("power state changed");
  same_code_a: assert property (d && c == 4'hF |-> out_codes.chan_a == out_codes.chan_b)
    else $error("channels differ after common load");
  cover property (d && c == 4'hE);
  cover property (d && c == 4'hD && $past(asleep));
  cover property (d && c == 4'hF);
endmodule
bind dual_dac_serial_control dac_ctrl_sva i_dac_ctrl_sva (.clk(clk), .nrst(nrst),
  .out_codes(out_codes), .out_enable(out_enable), .asleep(asleep),
  .last_control_code(last_control_code), .command_done(command_done));

// File: dual_dac_serial_control_tb.sv
// Self-checking bench of the converter control block
`timescale 1ns/1ps
module dual_dac_serial_control_tb;
  import dac_ctrl_pkg::*;
  logic                 clk  = 1'b0;
  logic                 nrst = 1'b0;
  logic                 strobe_n, sclk, sdata, out_enable, asleep, word_complete, command_done;
  pair_type             out_codes;
  logic [CODE_BITS-1:0] last_control_code;
  logic [DATA_BITS-1:0] ia, ib, oa, ob;
  logic                 sl;
  logic [24:0]          exp_q[$];
  logic [24:0]          e;
  int                   num_errors = 0;
  int                   cmp_count  = 0;
  int                   cycles     = 0;
  logic [3:0]           seq [23]   = '{4'h1, 4'h2, 4'h8, 4'hE, 4'h1, 4'h2, 4'hD, 4'h8, 4'hE,
    4'h9, 4'hE, 4'hA, 4'hF, 4'h0, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'hB, 4'hC, 4'hE, 4'hF};
  always #2.5 clk = ~clk;
  dual_dac_serial_control i_dual_dac_serial_control (.clk(clk), .nrst(nrst),
    .select_load_strobe_n(strobe_n), .serial_clk(sclk), .serial_data(sdata),
    .out_codes(out_codes), .out_enable(out_enable), .asleep(asleep),
    .last_control_code(last_control_code), .word_complete(word_complete),
    .command_done(command_done));
  serial_host_model i_serial_host_model (.clk(clk), .strobe_n(strobe_n), .sclk(sclk),
    .sdata(sdata));
  task automatic chk(input string n, input logic [24:0] x, input logic [24:0] y);
    cmp_count++;
    if (x !== y) begin
      num_errors++;
      $display("unexpected %s: expected %h seen %h", n, x, y);
    end
  endtask
  task automatic finish_test();
    $display("comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Expected state is noted before the word is sent
  task automatic word(input logic [3:0] c, input logic [9:0] d);
    case (c)
      4'h1, 4'h9: ia = d;
      4'h2, 4'hA: ib = d;
      4'hF: begin
        ia = d;
        ib = d;
      end
      default: ;
    endcase
    if (c inside {4'h8, 4'h9, 4'hA, 4'hF}) {oa, ob} = {ia, ib};
    if (c inside {4'h8, 4'h9, 4'hA, 4'hD, 4'hF}) sl = 1'b0;
    else if (c == 4'hE) sl = 1'b1;
    exp_q.push_back({oa, ob, sl, c});
    i_serial_host_model.send({c, d, 2'($urandom)});
  endtask
  always @(negedge clk) begin
    if (command_done === 1'b1) begin
      e = (exp_q.size() > 0) ? exp_q.pop_front() : 25'h1FFFFFF;
      chk("outputs", e, {out_codes, asleep, last_control_code});
      chk("out_enable", {24'h0, ~e[4]}, {24'h0, out_enable});
      chk("word_complete", 25'h1, {24'h0, word_complete});
    end
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      num_errors++;
      finish_test();
    end
  end
  initial begin
    void'($urandom(32'h596B2558));
    {ia, ib, oa, ob, sl} = '0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    repeat (4) @(negedge clk);
    chk("reset", 25'h0, {out_codes, asleep, last_control_code});
    chk("reset_enable", 25'h1, {23'h0, word_complete, out_enable});
    foreach (seq[i]) word(seq[i], 10'($urandom));
    word(4'hF, 10'h3FF);
    repeat (24) word(4'($urandom), 10'($urandom));
    repeat (20) @(negedge clk);
    chk("pending", 25'h0, 25'(exp_q.size()));
    finish_test();
  end
endmodule
